// ### design/pdh_device.sv
module pdh_device
    import pdh_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              clkEn,
    pdh_if.device                  port,
    input  wire logic [7:0]        lookupIndex,
    output logic [DATA_W-1:0]      lookupRed,
    output logic [DATA_W-1:0]      lookupGreen,
    output logic [DATA_W-1:0]      lookupBlue,
    output logic [7:0]             pixelMask,
    output logic                   calibrateEveryVsync,
    output logic                   trueColour24,
    output logic                   pedestalOn,
    output logic                   syncOnVideo,
    output logic                   mux2to1,
    output logic                   pipeReset,
    output logic                   muxPhase,
    output logic                   loadSync,
    output logic                   load_clock_out,
    output logic                   programmable_clock_out
);
    logic [DATA_W-1:0] redRam   [256];
    logic [DATA_W-1:0] greenRam [256];
    logic [DATA_W-1:0] blueRam  [256];

    logic [7:0]        addr_q,     addr_d;
    logic [7:0]        mask_q,     mask_d;
    logic [7:0]        cmdA_q,     cmdA_d;
    logic [7:0]        cmdB_q,     cmdB_d;
    logic [7:0]        cmdC_q,     cmdC_d;
    logic [7:0]        mode_q,     mode_d;
    pdh_colour_t       colour_q,   colour_d;
    logic [DATA_W-1:0] redStage_q, redStage_d;
    logic [DATA_W-1:0] grnStage_q, grnStage_d;
    logic [1:0]        pipeHist_q, pipeHist_d;
    logic [1:0]        loadHist_q, loadHist_d;
    logic [DATA_W-1:0] rdData_q,   rdData_d;
    logic              rdValid_q,  rdValid_d;
    logic              pipeRst_q,  pipeRst_d;
    logic              ldSync_q,   ldSync_d;
    logic              paletteWe;
    logic [DATA_W-1:0] wrValue;
    logic [DATA_W-1:0] ramValue;
    logic              wideBus;
    logic              wrStrobe;
    logic              rdStrobe;
    logic [1:0]        sel;

    assign sel      = {port.selHigh, port.selLow};
    assign wrStrobe = port.accessStrobe && !port.readNotWrite;
    assign rdStrobe = port.accessStrobe && port.readNotWrite;
    assign wideBus  = mode_q[MODE_WIDE_BUS_BIT];
    // narrow bus carries the top eight bits of each colour
    assign wrValue  = wideBus ? port.hostData : {port.hostData[7:0], 2'b00};

    always_comb begin
        case (colour_q)
            COL_RED:   ramValue = redRam[addr_q];
            COL_GREEN: ramValue = greenRam[addr_q];
            default:   ramValue = blueRam[addr_q];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // host port decode

    always_comb begin
        addr_d     = addr_q;
        mask_d     = mask_q;
        cmdA_d     = cmdA_q;
        cmdB_d     = cmdB_q;
        cmdC_d     = cmdC_q;
        mode_d     = mode_q;
        colour_d   = colour_q;
        redStage_d = redStage_q;
        grnStage_d = grnStage_q;
        pipeHist_d = pipeHist_q;
        loadHist_d = loadHist_q;
        rdData_d   = rdData_q;
        rdValid_d  = 1'b0;
        pipeRst_d  = 1'b0;
        ldSync_d   = 1'b0;
        paletteWe  = 1'b0;
        if (wrStrobe) begin
            case (sel)
                SEL_ADDRESS: begin
                    addr_d   = port.hostData[7:0];
                    colour_d = COL_RED;
                end
                SEL_CONTROL: begin
                    case (addr_q)
                        IDX_PIXEL_MASK: mask_d = port.hostData[7:0];
                        IDX_CMD_A:      cmdA_d = port.hostData[7:0];
                        IDX_CMD_B:      cmdB_d = port.hostData[7:0];
                        IDX_CMD_C:      cmdC_d = port.hostData[7:0];
                        default: ;
                    endcase
                end
                SEL_PALETTE: begin
                    case (colour_q)
                        COL_RED: begin
                            redStage_d = wrValue;
                            colour_d   = COL_GREEN;
                        end
                        COL_GREEN: begin
                            grnStage_d = wrValue;
                            colour_d   = COL_BLUE;
                        end
                        default: begin
                            paletteWe = 1'b1;
                            colour_d  = COL_RED;
                            addr_d    = addr_q + 8'h01;
                        end
                    endcase
                end
                default: begin
                    mode_d     = port.hostData[7:0];
                    pipeHist_d = {pipeHist_q[0], port.hostData[MODE_PIPE_RESET_BIT]};
                    loadHist_d = {loadHist_q[0], port.hostData[MODE_LOAD_SYNC_BIT]};
                    // sequence only counts over consecutive mode writes
                    pipeRst_d  = (pipeHist_q == 2'b10) && port.hostData[MODE_PIPE_RESET_BIT];
                    ldSync_d   = (loadHist_q == 2'b01) && !port.hostData[MODE_LOAD_SYNC_BIT];
                end
            endcase
        end else if (rdStrobe) begin
            rdValid_d = 1'b1;
            case (sel)
                SEL_ADDRESS: rdData_d = {2'b00, addr_q};
                SEL_CONTROL: begin
                    case (addr_q)
                        IDX_PIXEL_MASK: rdData_d = {2'b00, mask_q};
                        IDX_CMD_A:      rdData_d = {2'b00, cmdA_q};
                        IDX_CMD_B:      rdData_d = {2'b00, cmdB_q};
                        IDX_CMD_C:      rdData_d = {2'b00, cmdC_q};
                        default:        rdData_d = '0;
                    endcase
                end
                SEL_PALETTE: begin
                    rdData_d = wideBus ? ramValue : {2'b00, ramValue[DATA_W-1:2]};
                    case (colour_q)
                        COL_RED:   colour_d = COL_GREEN;
                        COL_GREEN: colour_d = COL_BLUE;
                        default: begin
                            colour_d = COL_RED;
                            addr_d   = addr_q + 8'h01;
                        end
                    endcase
                end
                default: rdData_d = {2'b00, mode_q};
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            addr_q     <= RST_ADDRESS;
            mask_q     <= RST_PIXEL_MASK;
            cmdA_q     <= RST_CMD;
            cmdB_q     <= RST_CMD;
            cmdC_q     <= RST_CMD;
            mode_q     <= RST_MODE;
            colour_q   <= COL_RED;
            redStage_q <= '0;
            grnStage_q <= '0;
            pipeHist_q <= 2'b00;
            loadHist_q <= 2'b11;
            rdData_q   <= '0;
            rdValid_q  <= 1'b0;
            pipeRst_q  <= 1'b0;
            ldSync_q   <= 1'b0;
        end else if (clkEn) begin
            addr_q     <= addr_d;
            mask_q     <= mask_d;
            cmdA_q     <= cmdA_d;
            cmdB_q     <= cmdB_d;
            cmdC_q     <= cmdC_d;
            mode_q     <= mode_d;
            colour_q   <= colour_d;
            redStage_q <= redStage_d;
            grnStage_q <= grnStage_d;
            pipeHist_q <= pipeHist_d;
            loadHist_q <= loadHist_d;
            rdData_q   <= rdData_d;
            rdValid_q  <= rdValid_d;
            pipeRst_q  <= pipeRst_d;
            ldSync_q   <= ldSync_d;
        end
    end

    // all three colours land together so a half-written entry never shows
    always_ff @(posedge sys_clk) begin
        if (clkEn && paletteWe) begin
            redRam[addr_q]   <= redStage_q;
            greenRam[addr_q] <= grnStage_q;
            blueRam[addr_q]  <= wrValue;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pixel side lookup and clocks

    logic [7:0]        maskedIdx;
    logic              muxPhase_q, muxPhase_d;
    logic [3:0]        loadCnt_q,  loadCnt_d;
    logic              loadClk_q,  loadClk_d;
    logic [3:0]        prgCnt_q,   prgCnt_d;
    logic              prgClk_q,   prgClk_d;
    logic [3:0]        prgHalf;

    assign maskedIdx = lookupIndex & mask_q;
    assign prgHalf   = (cmdC_q[CMD_C_DIV8_BIT] ? PRG_DIV_SLOW : PRG_DIV_FAST) >> 1;

    always_comb begin
        muxPhase_d = mux2to1 ? !muxPhase_q : 1'b0;
        if (pipeRst_q) begin
            muxPhase_d = 1'b0;
        end
        loadCnt_d = loadCnt_q + 4'h1;
        loadClk_d = loadClk_q;
        if (loadCnt_d == (LOAD_DIV >> 1)) begin
            loadCnt_d = 4'h0;
            loadClk_d = !loadClk_q;
        end
        if (ldSync_q) begin
            loadCnt_d = 4'h0;
            loadClk_d = 1'b0;
        end
        prgCnt_d = prgCnt_q + 4'h1;
        prgClk_d = prgClk_q;
        if (prgCnt_d >= prgHalf) begin
            prgCnt_d = 4'h0;
            prgClk_d = !prgClk_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            muxPhase_q <= 1'b0;
            loadCnt_q  <= 4'h0;
            loadClk_q  <= 1'b0;
            prgCnt_q   <= 4'h0;
            prgClk_q   <= 1'b0;
        end else if (clkEn) begin
            muxPhase_q <= muxPhase_d;
            loadCnt_q  <= loadCnt_d;
            loadClk_q  <= loadClk_d;
            prgCnt_q   <= prgCnt_d;
            prgClk_q   <= prgClk_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clkEn) begin
            lookupRed   <= redRam[maskedIdx];
            lookupGreen <= greenRam[maskedIdx];
            lookupBlue  <= blueRam[maskedIdx];
        end
    end

    assign port.devData         = rdData_q;
    assign port.devDataValid    = rdValid_q;
    assign pixelMask            = mask_q;
    assign calibrateEveryVsync  = cmdA_q[CMD_A_CAL_VSYNC_BIT];
    assign trueColour24         = cmdB_q[CMD_B_COLOUR_POS +: 3] == CMD_B_TRUE_COLOUR;
    assign pedestalOn           = cmdB_q[CMD_B_PEDESTAL_BIT];
    assign syncOnVideo          = cmdB_q[CMD_B_SYNC_BIT];
    assign mux2to1              = cmdC_q[CMD_C_MUX_BIT];
    assign pipeReset            = pipeRst_q;
    assign muxPhase             = muxPhase_q;
    assign loadSync             = ldSync_q;
    assign load_clock_out       = loadClk_q;
    assign programmable_clock_out = prgClk_q;
endmodule

// ### design/pdh_pkg.sv
package pdh_pkg;
    localparam int          DATA_W            = 10;
    // port selects as {select_high, select_low}
    localparam logic [1:0]  SEL_ADDRESS       = 2'h0;
    localparam logic [1:0]  SEL_PALETTE       = 2'h1;
    localparam logic [1:0]  SEL_CONTROL       = 2'h2;
    localparam logic [1:0]  SEL_MODE          = 2'h3;
    localparam logic [7:0]  IDX_PALETTE_FIRST = 8'h00;
    localparam logic [7:0]  IDX_PIXEL_MASK    = 8'h04;
    localparam logic [7:0]  IDX_CMD_A         = 8'h05;
    localparam logic [7:0]  IDX_CMD_B         = 8'h06;
    localparam logic [7:0]  IDX_CMD_C         = 8'h07;
    // mode register fields
    localparam int          MODE_PIPE_RESET_BIT = 0;
    localparam int          MODE_WIDE_BUS_BIT   = 1;
    localparam int          MODE_LOAD_SYNC_BIT  = 5;
    localparam logic [7:0]  MODE_NORMAL_10BIT   = 8'h0F;
    localparam logic [7:0]  MODE_PIPE_LOW       = 8'h0E;
    localparam logic [7:0]  MODE_LOAD_HIGH      = 8'h2F;
    // command register fields
    localparam int          CMD_A_CAL_VSYNC_BIT = 0;
    localparam int          CMD_B_COLOUR_POS    = 5;
    localparam logic [2:0]  CMD_B_TRUE_COLOUR   = 3'h7;
    localparam int          CMD_B_PEDESTAL_BIT  = 4;
    localparam int          CMD_B_SYNC_BIT      = 3;
    localparam int          CMD_C_MUX_BIT       = 6;
    localparam int          CMD_C_DIV8_BIT      = 0;
    localparam logic [3:0]  PRG_DIV_SLOW        = 4'h8;
    localparam logic [3:0]  PRG_DIV_FAST        = 4'h4;
    localparam logic [3:0]  LOAD_DIV            = 4'h2;
    // reset values
    localparam logic [7:0]  RST_ADDRESS       = 8'h00;
    localparam logic [7:0]  RST_PIXEL_MASK    = 8'hFF;
    localparam logic [7:0]  RST_CMD           = 8'h00;
    localparam logic [7:0]  RST_MODE          = 8'h00;
    // host register map, byte addresses
    localparam logic [3:0]  HOST_OFS_CMD      = 4'h0;
    localparam logic [3:0]  HOST_OFS_STATUS   = 4'h4;
    localparam logic [3:0]  HOST_OFS_INIT     = 4'h8;
    localparam int          HCMD_SEL_POS      = 10;
    localparam int          HCMD_RNW_BIT      = 12;
    localparam int          HSTAT_BUSY_BIT    = 16;
    localparam int          HSTAT_INIT_BIT    = 17;
    localparam logic [2:0]  INIT_STEPS        = 3'h5;

    typedef enum logic [1:0] {COL_RED, COL_GREEN, COL_BLUE} pdh_colour_t;

    function automatic logic [7:0] pdh_init_value(input logic [2:0] step);
        case (step)
            3'h1:    pdh_init_value = MODE_PIPE_LOW;
            3'h3:    pdh_init_value = MODE_LOAD_HIGH;
            default: pdh_init_value = MODE_NORMAL_10BIT;
        endcase
    endfunction
endpackage

// ### design/pdh_if.sv
interface pdh_if;
    import pdh_pkg::*;
    logic              selHigh;
    logic              selLow;
    logic              readNotWrite;
    logic              accessStrobe;
    logic [DATA_W-1:0] hostData;
    logic [DATA_W-1:0] devData;
    logic              devDataValid;

    modport device (
        input  selHigh,
        input  selLow,
        input  readNotWrite,
        input  accessStrobe,
        input  hostData,
        output devData,
        output devDataValid
    );
    modport host (
        output selHigh,
        output selLow,
        output readNotWrite,
        output accessStrobe,
        output hostData,
        input  devData,
        input  devDataValid
    );
endinterface

// ### design/pdh_host.sv
module pdh_host
    import pdh_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              clkEn,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    pdh_if.host                    port
);
    typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_WAIT_READ} pdh_state_t;

    pdh_state_t        state_q,   state_d;
    logic [1:0]        sel_q,     sel_d;
    logic              rnw_q,     rnw_d;
    logic [DATA_W-1:0] data_q,    data_d;
    logic [DATA_W-1:0] rdBack_q,  rdBack_d;
    logic              initRun_q, initRun_d;
    logic [2:0]        initStep_q, initStep_d;
    logic              rdPend_q,  rdPend_d;
    logic [31:0]       rdData_q,  rdData_d;
    logic              busy;
    logic              wrTake;

    assign busy            = (state_q != ST_IDLE) || initRun_q;
    // writes stall while a port cycle or the init sequence runs
    assign avs_waitrequest = (avs_write && busy) || (avs_read && !rdPend_q);
    assign wrTake          = avs_write && !busy;

    always_comb begin
        state_d    = state_q;
        sel_d      = sel_q;
        rnw_d      = rnw_q;
        data_d     = data_q;
        rdBack_d   = rdBack_q;
        initRun_d  = initRun_q;
        initStep_d = initStep_q;
        rdPend_d   = 1'b0;
        rdData_d   = rdData_q;
        if (avs_read && !rdPend_q) begin
            rdPend_d = 1'b1;
            case (avs_address)
                HOST_OFS_STATUS: rdData_d = {14'h0000, initRun_q, busy, 6'h00, rdBack_q};
                default:         rdData_d = 32'h0000_0000;
            endcase
        end
        case (state_q)
            ST_IDLE: begin
                if (initRun_q) begin
                    sel_d      = SEL_MODE;
                    rnw_d      = 1'b0;
                    data_d     = {2'b00, pdh_init_value(initStep_q)};
                    state_d    = ST_STROBE;
                    initStep_d = initStep_q + 3'h1;
                    initRun_d  = (initStep_q + 3'h1) != INIT_STEPS;
                end else if (wrTake && avs_address == HOST_OFS_CMD) begin
                    sel_d   = avs_writedata[HCMD_SEL_POS +: 2];
                    rnw_d   = avs_writedata[HCMD_RNW_BIT];
                    data_d  = avs_writedata[DATA_W-1:0];
                    state_d = ST_STROBE;
                end else if (wrTake && avs_address == HOST_OFS_INIT && avs_writedata[0]) begin
                    initRun_d  = 1'b1;
                    initStep_d = 3'h0;
                end
            end
            ST_STROBE: state_d = rnw_q ? ST_WAIT_READ : ST_IDLE;
            ST_WAIT_READ: begin
                if (port.devDataValid) begin
                    rdBack_d = port.devData;
                    state_d  = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= ST_IDLE;
            sel_q      <= SEL_ADDRESS;
            rnw_q      <= 1'b0;
            data_q     <= '0;
            rdBack_q   <= '0;
            initRun_q  <= 1'b0;
            initStep_q <= 3'h0;
            rdPend_q   <= 1'b0;
            rdData_q   <= 32'h0000_0000;
        end else if (clkEn) begin
            state_q    <= state_d;
            sel_q      <= sel_d;
            rnw_q      <= rnw_d;
            data_q     <= data_d;
            rdBack_q   <= rdBack_d;
            initRun_q  <= initRun_d;
            initStep_q <= initStep_d;
            rdPend_q   <= rdPend_d;
            rdData_q   <= rdData_d;
        end
    end

    assign avs_readdata      = rdData_q;
    assign port.accessStrobe = (state_q == ST_STROBE);
    assign port.selHigh      = sel_q[1];
    assign port.selLow       = sel_q[0];
    assign port.readNotWrite = rnw_q;
    assign port.hostData     = data_q;
endmodule

// ### test/pdh_chk.sv
module pdh_chk
    import pdh_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic              selHigh,
    input wire logic              selLow,
    input wire logic              readNotWrite,
    input wire logic              accessStrobe,
    input wire logic [DATA_W-1:0] hostData,
    input wire logic [DATA_W-1:0] devData,
    input wire logic              devDataValid
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    strobe_pulse_a: assert property (accessStrobe |=> !accessStrobe)
        else $error("port strobe held longer than one cycle");
    read_answer_a: assert property (accessStrobe && readNotWrite |=> devDataValid)
        else $error("read strobe without answer next cycle");
    answer_cause_a: assert property (devDataValid |-> $past(accessStrobe) && $past(readNotWrite))
        else $error("answer without a read strobe before it");
    valid_pulse_a: assert property (devDataValid |=> !devDataValid)
        else $error("answer valid longer than one cycle");
    // read data must not drift between answers
    devdata_hold_a: assert property (!devDataValid |-> $stable(devData))
        else $error("read data changed without an answer");
    mode_write_a: assert property (accessStrobe && selHigh && selLow |-> !readNotWrite)
        else $error("mode register accessed as a read");
    pipe_seq_a: assert property (accessStrobe && selHigh && selLow && hostData[7:0] == MODE_PIPE_LOW
        |=> ##1 accessStrobe && selHigh && selLow && hostData[7:0] == MODE_NORMAL_10BIT)
        else $error("pipe reset bit not returned high");
    load_seq_a: assert property (accessStrobe && selHigh && selLow && hostData[7:0] == MODE_LOAD_HIGH
        |=> ##1 accessStrobe && selHigh && selLow && hostData[7:0] == MODE_NORMAL_10BIT)
        else $error("load sync bit not returned low");
endmodule

// ### test/test_palette_dac_host_setup.sv
module test_palette_dac_host_setup
    import pdh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              sys_clk = 1'b0;
    logic              rstn = 1'b0;
    logic [3:0]        avsAddress = 4'h0;
    logic              avsRead = 1'b0;
    logic              avsWrite = 1'b0;
    logic [31:0]       avsWritedata = 32'h0000_0000;
    logic [31:0]       avsReaddata;
    logic              avsWaitrequest;
    logic [7:0]        lookupIndex = 8'h00;
    logic [DATA_W-1:0] lkR, lkG, lkB;
    logic [7:0]        pixelMask;
    logic              calib, tc24, pedestal, syncVid, mux2, pipeReset, loadSync, prgClk;
    logic              prgLast = 1'b0;
    logic              muxPh, ldClk;
    logic              clkEn = 1'b1;
    int                ldHigh = 0;
    int                phHigh = 0;
    int                failures = 0;
    int                checksDone = 0;
    int                pipeCount = 0;
    int                loadCount = 0;
    int                prgRise = 0;
    logic [9:0]        pal [6] = '{10'h3FF, 10'h155, 10'h2AA, 10'h001, 10'h002, 10'h003};

    always #2.5 sys_clk = ~sys_clk;

    // observe on the falling edge so register updates have settled
    always @(negedge sys_clk) begin
        pipeCount += pipeReset;
        loadCount += loadSync;
        prgRise += (prgClk && !prgLast);
        prgLast = prgClk;
        ldHigh += ldClk;
        phHigh += muxPh;
    end

    ////////////////////////////////////////////////////////////////////////
    pdh_if pdh_if_inst ();
    pdh_host pdh_host_inst (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .port(pdh_if_inst));
    pdh_device pdh_device_inst (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .port(pdh_if_inst),
        .lookupIndex(lookupIndex), .lookupRed(lkR), .lookupGreen(lkG), .lookupBlue(lkB),
        .pixelMask(pixelMask), .calibrateEveryVsync(calib), .trueColour24(tc24), .pedestalOn(pedestal),
        .syncOnVideo(syncVid), .mux2to1(mux2), .pipeReset(pipeReset), .muxPhase(muxPh), .loadSync(loadSync),
        .load_clock_out(ldClk), .programmable_clock_out(prgClk));
    pdh_chk pdh_chk_inst (.sys_clk(sys_clk), .rstn(rstn), .selHigh(pdh_if_inst.selHigh),
        .selLow(pdh_if_inst.selLow), .readNotWrite(pdh_if_inst.readNotWrite),
        .accessStrobe(pdh_if_inst.accessStrobe), .hostData(pdh_if_inst.hostData),
        .devData(pdh_if_inst.devData), .devDataValid(pdh_if_inst.devDataValid));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic avm(input logic [3:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= d;
        n = 0;
        // the accepting edge is the rising edge that sees waitrequest low
        do begin
            @(posedge sys_clk);
            n++;
            if (n > 500) begin
                failures++;
                conclude();
            end
        end while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask

    task automatic waitClear(input int b, output logic [31:0] s);
        s = 32'hFFFF_FFFF;
        for (int i = 0; i < 100 && s[b] !== 1'b0; i++) avm(HOST_OFS_STATUS, 1'b0, 32'h0, s);
        if (s[b] !== 1'b0) begin
            failures++;
            conclude();
        end
    endtask

    task automatic port(input logic [1:0] sel, input logic rnw, input logic [9:0] d, output logic [9:0] q);
        logic [31:0] s;
        avm(HOST_OFS_CMD, 1'b1, {19'h0, rnw, sel, d}, s);
        waitClear(HSTAT_BUSY_BIT, s);
        q = s[9:0];
    endtask

    task automatic look(input logic [7:0] i, input int e);
        lookupIndex <= i;
        repeat (3) @(posedge sys_clk);
        check("lookRed", lkR, pal[e * 3]);
        check("lookGreen", lkG, pal[e * 3 + 1]);
        check("lookBlue", lkB, pal[e * 3 + 2]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        logic [31:0] s;
        avm(4'hC, 1'b1, 32'hFFFF_FFFF, s);
        avm(4'hC, 1'b0, 32'h0, s);
        check("unmapped", s, 32'h0);
        avm(HOST_OFS_STATUS, 1'b0, 32'h0, s);
        check("status", s, 32'h0);
        check("maskReset", pixelMask, RST_PIXEL_MASK);
        $display("test reset done");
    endtask

    task automatic testInit();
        logic [31:0] s;
        avm(HOST_OFS_INIT, 1'b1, 32'h0, s);
        avm(HOST_OFS_STATUS, 1'b0, 32'h0, s);
        check("initIgnored", s[HSTAT_INIT_BIT], 1'b0);
        avm(HOST_OFS_INIT, 1'b1, 32'h1, s);
        waitClear(HSTAT_INIT_BIT, s);
        check("pipeReset", pipeCount, 1);
        check("loadSync", loadCount, 1);
        $display("test init done");
    endtask

    task automatic testRegs();
        logic [7:0] val [4] = '{8'hFF, 8'h01, 8'hE0, 8'h41};
        logic [9:0] q;
        for (int i = 0; i < 4; i++) begin
            port(SEL_ADDRESS, 1'b0, 10'(IDX_PIXEL_MASK + i), q);
            port(SEL_CONTROL, 1'b0, {2'h0, val[i]}, q);
            port(SEL_CONTROL, 1'b1, 10'h0, q);
            check("ctrlBack", q[7:0], val[i]);
        end
        check("mask", pixelMask, 8'hFF);
        check("calib", calib, 1'b1);
        check("colour", {tc24, pedestal, syncVid}, 3'h4);
        check("mux", mux2, 1'b1);
        prgRise = 0;
        ldHigh = 0;
        phHigh = 0;
        repeat (64) @(posedge sys_clk);
        check("prgDiv8", prgRise, 8);
        check("loadDiv2", ldHigh, 32);
        check("muxPhase", phHigh, 32);
        // a low enable must freeze the divider
        clkEn <= 1'b0;
        @(posedge sys_clk);
        prgRise = 0;
        repeat (16) @(posedge sys_clk);
        check("frozen", prgRise, 0);
        clkEn <= 1'b1;
        port(SEL_ADDRESS, 1'b0, 10'h008, q);
        port(SEL_CONTROL, 1'b0, 10'h033, q);
        port(SEL_CONTROL, 1'b1, 10'h0, q);
        check("badIndex", q, 10'h0);
        check("maskKept", pixelMask, 8'hFF);
        $display("test registers done");
    endtask

    task automatic testPalette();
        logic [9:0] q;
        port(SEL_ADDRESS, 1'b0, 10'(IDX_PALETTE_FIRST), q);
        for (int i = 0; i < 6; i++) port(SEL_PALETTE, 1'b0, pal[i], q);
        look(8'h01, 1);
        look(8'h00, 0);
        port(SEL_ADDRESS, 1'b0, 10'h000, q);
        for (int i = 0; i < 6; i++) begin
            port(SEL_PALETTE, 1'b1, 10'h0, q);
            check("palBack", q, pal[i]);
        end
        // narrow bus: byte lands in colour bits 9:2
        port(SEL_MODE, 1'b0, 10'h00D, q);
        port(SEL_ADDRESS, 1'b0, 10'h002, q);
        for (int i = 0; i < 3; i++) port(SEL_PALETTE, 1'b0, 10'h3A5, q);
        port(SEL_ADDRESS, 1'b0, 10'h002, q);
        port(SEL_PALETTE, 1'b1, 10'h0, q);
        check("narrowBack", q, 10'h0A5);
        lookupIndex <= 8'h02;
        repeat (3) @(posedge sys_clk);
        check("narrowLook", lkR, 10'h294);
        // a cleared mask folds every index onto entry zero
        port(SEL_ADDRESS, 1'b0, 10'(IDX_PIXEL_MASK), q);
        port(SEL_CONTROL, 1'b0, 10'h000, q);
        look(8'h01, 0);
        $display("test palette done");
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        testReset();
        testInit();
        testRegs();
        testPalette();
        conclude();
    end
endmodule
